// file: asp_framer.sv
// Shared serial frame engine: clocks, slot timing, shifting
`timescale 1ns/1ps
module asp_framer
    import asp_pkg::*;
#(
    parameter int SW = ASP_SAMPLE_W,
    parameter int DIV = ASP_BCLK_DIV
) (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic [7:0] ctrl_a_in,
    input wire logic [7:0] ctrl_b_in,
    input wire logic order_r_in,
    input wire logic [1:0] pair_in,
    input wire logic bclk_pin_in,
    input wire logic fclk_pin_in,
    input wire logic sdi_in,
    input wire logic [SW-1:0] tx_l_in,
    input wire logic [SW-1:0] tx_r_in,
    output logic bclk_out,
    output logic fclk_out,
    output logic sdo_out,
    output logic [SW-1:0] rx_l_out,
    output logic [SW-1:0] rx_r_out,
    output logic rx_valid_out,
    output logic tx_take_out
);
    typedef struct packed {
        logic [2:0] bs;
        logic [2:0] fs;
        logic [7:0] div;
        logic bclk;
        logic fclk;
        logic fprev;
        logic [8:0] cnt;
        logic [SW-1:0] sh_tx;
        logic [SW-1:0] sh_rx;
        logic [SW-1:0] tx_r;
        logic [SW-1:0] rx_l;
        logic [SW-1:0] rx_lo;
        logic [SW-1:0] rx_ro;
        logic sdo;
        logic rx_v;
        logic take;
    } asp_frm_s;

    asp_frm_s s_q, s_d;

    always_comb begin
        logic master, pulse, bpol, fpol, lsbf, drive_edge, samp_edge;
        logic fnow, left_start, frame_start;
        logic [8:0] flen, half, slotw, pos, dly, bitn;
        logic [3:0] slot, slots;
        logic first_in_pair;
        pos = 9'h000;
        bitn = 9'h000;
        slot = 4'h0;
        first_in_pair = 1'b0;
        s_d = s_q;
        master = ctrl_a_in[ASP_A_MASTER_BIT];
        pulse = ctrl_a_in[ASP_A_PULSE_BIT];
        bpol = ctrl_a_in[ASP_A_BPOL_BIT];
        fpol = ctrl_a_in[ASP_A_FPOL_BIT];
        lsbf = ctrl_b_in[ASP_B_LSBF_BIT];
        flen = asp_frame_len(ctrl_b_in[ASP_B_LEN_LSB +: 3]); // R9
        slots = asp_slots(ctrl_a_in[ASP_A_CHAN_LSB +: 2]); // R5
        dly = asp_delay(ctrl_b_in[ASP_B_DELAY_LSB +: 2]); // R15
        half = flen >> 1;
        slotw = (slots == 4'h2) ? half : 9'(flen / 9'(slots)); // R7
        s_d.bs = {s_q.bs[1:0], bclk_pin_in};
        s_d.fs = {s_q.fs[1:0], fclk_pin_in};
        s_d.rx_v = 1'b0;
        s_d.take = 1'b0;
        // Master: bit clock from divider, one edge per DIV cycles
        drive_edge = 1'b0;
        samp_edge = 1'b0;
        if (master) begin // R8
            s_d.div = s_q.div + 8'h01;
            if (s_q.div == 8'(DIV - 1)) begin
                s_d.div = 8'h00;
                s_d.bclk = !s_q.bclk; // R10
                // Edge about to happen leaves the clock at the polarity level
                drive_edge = (s_q.bclk != bpol); // R3
                samp_edge = !drive_edge; // R19
            end
        end else begin
            drive_edge = (s_q.bs[2] != s_q.bs[1]) && (s_q.bs[1] == bpol); // R3
            samp_edge = (s_q.bs[2] != s_q.bs[1]) && (s_q.bs[1] != bpol); // R19
        end
        fnow = master ? s_q.fclk : s_q.fs[2];
        // Left frame starts on the edge set by polarity, pulse mode on the pulse start
        left_start = pulse ? (fnow && !s_q.fprev) : (fnow != s_q.fprev && fnow == fpol); // R1 R4
        frame_start = 1'b0;
        if (samp_edge) begin
            s_d.fprev = fnow;
            if (!master && left_start)
                frame_start = 1'b1; // R2
        end
        // Position counts drive edges since the frame edge
        if (drive_edge) begin
            s_d.cnt = (s_q.cnt + 9'h001 >= flen) ? 9'h000 : s_q.cnt + 9'h001;
            if (master) begin
                if (pulse)
                    s_d.fclk = (s_d.cnt == 9'h000); // R1
                else
                    s_d.fclk = (s_d.cnt < half) ? fpol : !fpol; // R4
            end
            pos = s_d.cnt;
            slot = 4'(pos / slotw);
            bitn = pos - 9'(slot) * slotw - dly;
            first_in_pair = !slot[0];
            if (pos == 9'h000) begin
                s_d.take = 1'b1;
            end
            // Stereo carries data in both slots, otherwise only the selected pair does; other slots hold zero
            if ((slots == 4'h2 || slot[2:1] == pair_in) && pos - 9'(slot) * slotw >= dly
                && bitn < 9'(SW)) begin // R20
                if (bitn == 9'h000)
                    s_d.sh_tx = (first_in_pair ^ order_r_in) ? tx_l_in : s_q.tx_r; // R11 R12
                else
                    s_d.sh_tx = lsbf ? s_q.sh_tx >> 1 : s_q.sh_tx << 1;
                s_d.sdo = lsbf ? s_d.sh_tx[0] : s_d.sh_tx[SW-1]; // R14 R16
            end else begin
                s_d.sdo = 1'b0; // R6
            end
            if (pos == 9'h000)
                s_d.tx_r = tx_r_in;
        end
        if (frame_start)
            s_d.cnt = 9'h000;
        // Receive shifts on the opposite edge, at the same count as the last drive edge
        if (samp_edge) begin
            pos = s_q.cnt;
            slot = 4'(pos / slotw);
            bitn = pos - 9'(slot) * slotw - dly;
            if ((slots == 4'h2 || slot[2:1] == pair_in) && pos - 9'(slot) * slotw >= dly
                && bitn < 9'(SW)) begin
                s_d.sh_rx = lsbf ? {sdi_in, s_q.sh_rx[SW-1:1]}
                    : {s_q.sh_rx[SW-2:0], sdi_in}; // R14 R19
                if (bitn == 9'(SW - 1)) begin
                    if (slot[0] ^ order_r_in) begin
                        s_d.rx_lo = s_q.rx_l; // R11 R12
                        s_d.rx_ro = s_d.sh_rx;
                        s_d.rx_v = 1'b1;
                    end else begin
                        s_d.rx_l = s_d.sh_rx;
                    end
                end
            end
        end
        if (srst_in) begin
            s_d = '0; // R18
        end
    end

    always_ff @(posedge clk_in) begin
        s_q <= s_d;
    end

    assign bclk_out = s_q.bclk;
    assign fclk_out = s_q.fclk;
    assign sdo_out = s_q.sdo;
    assign rx_l_out = s_q.rx_lo;
    assign rx_r_out = s_q.rx_ro;
    assign rx_valid_out = s_q.rx_v;
    assign tx_take_out = s_q.take;
endmodule : asp_framer

// file: asp_pkg.sv
// Constants and functions shared by both ends of the serial audio port
//
// Notes on behaviour
// R1 - Frame style bit: half duty or pulse
// R2 - Slave pulse frame sync at least one bit clock
// R3 - Bit clock polarity picks the data change edge
// R4 - Frame polarity picks the left frame start edge
// R5 - Channels field: stereo, four or eight slots
// R6 - Data line always driven, never floats
// R7 - Slots grouped as left/right pairs
// R8 - Mode bit: slave or master driving clocks
// R9 - Frame length code: 64/32/48/128/256 bit clocks
// R10 - Bit clock rate is frame length times rate
// R11 - Capture order bit: left or right first
// R12 - Playback order bit: left or right first; the codec end orders playback by the capture order bit instead
// R13 - Program order bits with pair selects
// R14 - Bit order: msb first or lsb first
// R15 - Delay code: 1, 0, 8 or 16 bit clocks
// R16 - Delay 0 left, 8 right justified
// R17 - Never delay 16 if sample overruns half frame; the framer still accepts delay 16 and cuts the word off at the slot end
// R18 - Reset gives slave and zero fields
// R19 - Receiver samples on the opposite edge
// R20 - Pair select picks pair one to four; the codec end takes playback from the capture pair select instead
package asp_pkg;
    localparam logic [15:0] ASP_CTRL_A_OFS = 16'h4015;
    localparam logic [15:0] ASP_CTRL_B_OFS = 16'h4016;
    localparam logic [15:0] ASP_PAIR_DAC_OFS = 16'h4017;
    localparam logic [15:0] ASP_PAIR_ADC_OFS = 16'h4018;
    localparam logic [7:0] ASP_CTRL_RST = 8'h00;
    localparam int ASP_A_MASTER_BIT = 0;
    localparam int ASP_A_CHAN_LSB = 1;
    localparam int ASP_A_FPOL_BIT = 3;
    localparam int ASP_A_BPOL_BIT = 4;
    localparam int ASP_A_PULSE_BIT = 5;
    localparam int ASP_B_DELAY_LSB = 0;
    localparam int ASP_B_LSBF_BIT = 2;
    localparam int ASP_B_DACR_BIT = 3;
    localparam int ASP_B_ADCR_BIT = 4;
    localparam int ASP_B_LEN_LSB = 5;
    localparam int ASP_DAC_PAIR_LSB = 5;
    localparam int ASP_ADC_PAIR_LSB = 0;
    localparam int ASP_SAMPLE_W = 24;
    localparam int ASP_CLK_HZ = 10_000_000;
    localparam int ASP_BCLK_DIV = 4;
    localparam logic [8:0] ASP_DELAY_LEFTJ = 9'h000;
    localparam logic [8:0] ASP_DELAY_I2S = 9'h001;
    localparam logic [8:0] ASP_DELAY_RIGHTJ = 9'h008;
    localparam logic [8:0] ASP_DELAY_SIXTEEN = 9'h010;

    function automatic logic [8:0] asp_frame_len(input logic [2:0] code);
        unique case (code)
            3'h1: asp_frame_len = 9'h020;
            3'h2: asp_frame_len = 9'h030;
            3'h3: asp_frame_len = 9'h080;
            3'h4: asp_frame_len = 9'h100;
            default: asp_frame_len = 9'h040;
        endcase
    endfunction : asp_frame_len

    function automatic logic [8:0] asp_delay(input logic [1:0] code);
        unique case (code)
            2'h0: asp_delay = ASP_DELAY_I2S;
            2'h1: asp_delay = ASP_DELAY_LEFTJ;
            2'h2: asp_delay = ASP_DELAY_RIGHTJ;
            default: asp_delay = ASP_DELAY_SIXTEEN;
        endcase
    endfunction : asp_delay

    function automatic logic [3:0] asp_slots(input logic [1:0] code);
        unique case (code)
            2'h1: asp_slots = 4'h4;
            2'h2: asp_slots = 4'h8;
            default: asp_slots = 4'h2;
        endcase
    endfunction : asp_slots
endpackage : asp_pkg

// file: asp_if.sv
// Serial audio link between codec port and host port
`timescale 1ns/1ps
interface asp_if;
    logic bclk_dev_o;
    logic bclk_dev_oe_n;
    logic bclk_host_o;
    logic bclk_host_oe_n;
    logic fclk_dev_o;
    logic fclk_dev_oe_n;
    logic fclk_host_o;
    logic fclk_host_oe_n;
    logic bclk;
    logic fclk;
    logic dac_data;
    logic adc_data;
    // Slave end releases the pin, master end drives it
    assign bclk = !bclk_dev_oe_n ? bclk_dev_o : (!bclk_host_oe_n ? bclk_host_o : 1'b0);
    assign fclk = !fclk_dev_oe_n ? fclk_dev_o : (!fclk_host_oe_n ? fclk_host_o : 1'b0);
    modport codec (
        input bclk, fclk, dac_data,
        output bclk_dev_o, bclk_dev_oe_n, fclk_dev_o, fclk_dev_oe_n, adc_data
    );
    modport host (
        input bclk, fclk, adc_data,
        output bclk_host_o, bclk_host_oe_n, fclk_host_o, fclk_host_oe_n, dac_data
    );
endinterface : asp_if

// file: asp_codec_port.sv
// Codec end: control registers and serial port
`timescale 1ns/1ps
module asp_codec_port
    import asp_pkg::*;
(
    input wire logic clk_in,
    input wire logic srst_in,
    asp_if.codec link,
    input wire logic [15:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    input wire logic [23:0] adc_l_in,
    input wire logic [23:0] adc_r_in,
    output logic adc_take_out,
    output logic [23:0] dac_l_out,
    output logic [23:0] dac_r_out,
    output logic dac_valid_out
);
    typedef struct packed {
        logic [7:0] ctrl_a;
        logic [7:0] ctrl_b;
        logic [7:0] pair_dac;
        logic [7:0] pair_adc;
        logic [7:0] rdata;
    } asp_cdc_s;

    asp_cdc_s s_q, s_d;
    logic bclk_int, fclk_int;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        s_d = s_q;
        s_d.rdata = 8'h00;
        if (reg_wr_in) begin
            unique case (reg_addr_in)
                ASP_CTRL_A_OFS: s_d.ctrl_a = reg_wdata_in;
                ASP_CTRL_B_OFS: s_d.ctrl_b = reg_wdata_in;
                ASP_PAIR_DAC_OFS: s_d.pair_dac = reg_wdata_in;
                ASP_PAIR_ADC_OFS: s_d.pair_adc = reg_wdata_in;
                default: ;
            endcase
        end
        if (reg_rd_in) begin
            unique case (reg_addr_in)
                ASP_CTRL_A_OFS: s_d.rdata = s_q.ctrl_a;
                ASP_CTRL_B_OFS: s_d.rdata = s_q.ctrl_b;
                ASP_PAIR_DAC_OFS: s_d.rdata = s_q.pair_dac;
                ASP_PAIR_ADC_OFS: s_d.rdata = s_q.pair_adc;
                default: s_d.rdata = 8'h00;
            endcase
        end
        if (srst_in)
            s_d = '0; // R18
    end

    always_ff @(posedge clk_in) begin
        s_q <= s_d;
    end

    ////////////////////////////////////////////////////////////////////////
    // Capture samples go out, playback samples come in; one framer serves both
    asp_framer u_frm (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .ctrl_a_in(s_q.ctrl_a),
        .ctrl_b_in(s_q.ctrl_b),
        .order_r_in(s_q.ctrl_b[ASP_B_ADCR_BIT]), // R11
        .pair_in(s_q.pair_adc[ASP_ADC_PAIR_LSB +: 2]), // R20
        .bclk_pin_in(link.bclk),
        .fclk_pin_in(link.fclk),
        .sdi_in(link.dac_data),
        .tx_l_in(adc_l_in),
        .tx_r_in(adc_r_in),
        .bclk_out(bclk_int),
        .fclk_out(fclk_int),
        .sdo_out(link.adc_data),
        .rx_l_out(dac_l_out),
        .rx_r_out(dac_r_out),
        .rx_valid_out(dac_valid_out),
        .tx_take_out(adc_take_out)
    );

    // Limitation: one framer means playback uses the capture order and pair
    assign link.bclk_dev_o = bclk_int;
    assign link.fclk_dev_o = fclk_int;
    assign link.bclk_dev_oe_n = !s_q.ctrl_a[ASP_A_MASTER_BIT]; // R8
    assign link.fclk_dev_oe_n = !s_q.ctrl_a[ASP_A_MASTER_BIT]; // R8
    assign reg_rdata_out = s_q.rdata;
endmodule : asp_codec_port

// file: asp_host_port.sv
// Host end: own control registers and serial port
`timescale 1ns/1ps
module asp_host_port
    import asp_pkg::*;
(
    input wire logic clk_in,
    input wire logic srst_in,
    asp_if.host link,
    input wire logic [1:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    input wire logic [23:0] play_l_in,
    input wire logic [23:0] play_r_in,
    output logic play_take_out,
    output logic [23:0] rec_l_out,
    output logic [23:0] rec_r_out,
    output logic rec_valid_out
);
    typedef struct packed {
        logic [7:0] ctrl_a;
        logic [7:0] ctrl_b;
        logic [7:0] pair;
        logic [7:0] rdata;
    } asp_hst_s;

    asp_hst_s s_q, s_d;
    logic bclk_int, fclk_int;

    always_comb begin
        s_d = s_q;
        s_d.rdata = 8'h00;
        if (reg_wr_in) begin
            unique case (reg_addr_in)
                2'h0: s_d.ctrl_a = reg_wdata_in;
                2'h1: s_d.ctrl_b = reg_wdata_in;
                2'h2: s_d.pair = reg_wdata_in;
                default: ;
            endcase
        end
        if (reg_rd_in) begin
            unique case (reg_addr_in)
                2'h0: s_d.rdata = s_q.ctrl_a;
                2'h1: s_d.rdata = s_q.ctrl_b;
                2'h2: s_d.rdata = s_q.pair;
                default: s_d.rdata = 8'h00;
            endcase
        end
        if (srst_in)
            s_d = '0;
    end

    always_ff @(posedge clk_in) begin
        s_q <= s_d;
    end

    asp_framer u_frm (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .ctrl_a_in(s_q.ctrl_a),
        .ctrl_b_in(s_q.ctrl_b),
        .order_r_in(s_q.ctrl_b[ASP_B_DACR_BIT]), // R12
        .pair_in(s_q.pair[1:0]), // R13
        .bclk_pin_in(link.bclk),
        .fclk_pin_in(link.fclk),
        .sdi_in(link.adc_data),
        .tx_l_in(play_l_in),
        .tx_r_in(play_r_in),
        .bclk_out(bclk_int),
        .fclk_out(fclk_int),
        .sdo_out(link.dac_data),
        .rx_l_out(rec_l_out),
        .rx_r_out(rec_r_out),
        .rx_valid_out(rec_valid_out),
        .tx_take_out(play_take_out)
    );

    assign link.bclk_host_o = bclk_int;
    assign link.fclk_host_o = fclk_int;
    assign link.bclk_host_oe_n = !s_q.ctrl_a[ASP_A_MASTER_BIT]; // R8
    assign link.fclk_host_oe_n = !s_q.ctrl_a[ASP_A_MASTER_BIT]; // R8
    assign reg_rdata_out = s_q.rdata;
endmodule : asp_host_port

// file: asp_link_checker.sv
// Assertions on the clock pins between the codec end and the host end
`timescale 1ns/1ps
module asp_link_checker (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic bclk_dev_o,
    input wire logic bclk_dev_oe_n,
    input wire logic bclk_host_o,
    input wire logic bclk_host_oe_n,
    input wire logic fclk_dev_o,
    input wire logic fclk_dev_oe_n,
    input wire logic fclk_host_o,
    input wire logic fclk_host_oe_n
);
    logic dchg_q;
    logic hchg_q;
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (srst_in);
    ////////////////////////////////////////////////////////////////////////////////
    // Frame clock register may trail the bit clock register by one cycle
    always_ff @(posedge clk_in) begin
        dchg_q <= $changed(bclk_dev_o);
        hchg_q <= $changed(bclk_host_o);
    end
    // Half period of 4 clocks: only valid for the default divider
    sequence s_dev_hi;
        bclk_dev_o [*4] ##1 !bclk_dev_o;
    endsequence
    sequence s_dev_lo;
        !bclk_dev_o [*4] ##1 bclk_dev_o;
    endsequence
    sequence s_host_hi;
        bclk_host_o [*4] ##1 !bclk_host_o;
    endsequence
    sequence s_host_lo;
        !bclk_host_o [*4] ##1 bclk_host_o;
    endsequence
    ////////////////////////////////////////////////////////////////////////////////
    a_bclk_one_drv: assert property (bclk_dev_oe_n || bclk_host_oe_n)
        else $error("bit clock driven by both ends");
    a_fclk_one_drv: assert property (fclk_dev_oe_n || fclk_host_oe_n)
        else $error("frame clock driven by both ends");
    a_reset_release: assert property (disable iff (1'b0) srst_in |=> bclk_dev_oe_n &&
        bclk_host_oe_n && fclk_dev_oe_n && fclk_host_oe_n)
        else $error("clock pins not released after reset");
    a_dev_bclk_hi: assert property ($rose(bclk_dev_o) && !bclk_dev_oe_n &&
        !$past(bclk_dev_oe_n) |-> s_dev_hi) else $error("codec bit clock high phase wrong");
    a_dev_bclk_lo: assert property ($fell(bclk_dev_o) && !bclk_dev_oe_n &&
        !$past(bclk_dev_oe_n) |-> s_dev_lo) else $error("codec bit clock low phase wrong");
    a_host_bclk_hi: assert property ($rose(bclk_host_o) && !bclk_host_oe_n &&
        !$past(bclk_host_oe_n) |-> s_host_hi) else $error("host bit clock high phase wrong");
    a_host_bclk_lo: assert property ($fell(bclk_host_o) && !bclk_host_oe_n &&
        !$past(bclk_host_oe_n) |-> s_host_lo) else $error("host bit clock low phase wrong");
    a_dev_fclk_edge: assert property ($changed(fclk_dev_o) && !fclk_dev_oe_n &&
        !$past(fclk_dev_oe_n) |-> $changed(bclk_dev_o) || dchg_q)
        else $error("codec frame clock moved away from a bit clock edge");
    a_host_fclk_edge: assert property ($changed(fclk_host_o) && !fclk_host_oe_n &&
        !$past(fclk_host_oe_n) |-> $changed(bclk_host_o) || hchg_q)
        else $error("host frame clock moved away from a bit clock edge");
endmodule : asp_link_checker

// file: audio_serial_port_formatter_tb.sv
// Self-checking bench: codec end and host end joined by the link
`timescale 1ns/1ps
module audio_serial_port_formatter_tb
    import asp_pkg::*;
;
    localparam int LIMIT = 100000;
    logic clk_in = 1'b0;
    logic srst_in = 1'b1;
    logic [15:0] c_addr = 16'h0000;
    logic [1:0] h_addr = 2'h0;
    logic [7:0] c_wd = 8'h00, h_wd = 8'h00, c_rdata, h_rdata;
    logic c_wr = 1'b0, c_rd = 1'b0, h_wr = 1'b0, h_rd = 1'b0, dac_v, rec_v, bpol, fpol;
    logic [23:0] adc_l = 24'h0, adc_r = 24'h0, play_l = 24'h0, play_r = 24'h0;
    logic [23:0] dac_l, dac_r, rec_l, rec_r;
    logic c_take, h_take;
    logic [31:0] seed = 32'h8bf4;
    int err_count = 0;
    int n_tests = 0;
    int cyc = 0;
    ////////////////////////////////////////////////////////////////////////////////
    asp_if asp_if_i ();
    asp_codec_port asp_codec_port_i (.clk_in(clk_in), .srst_in(srst_in), .link(asp_if_i.codec),
        .reg_addr_in(c_addr), .reg_wdata_in(c_wd), .reg_wr_in(c_wr), .reg_rd_in(c_rd),
        .reg_rdata_out(c_rdata), .adc_l_in(adc_l), .adc_r_in(adc_r),
        .adc_take_out(c_take),
        .dac_l_out(dac_l), .dac_r_out(dac_r), .dac_valid_out(dac_v));
    asp_host_port asp_host_port_i (.clk_in(clk_in), .srst_in(srst_in), .link(asp_if_i.host),
        .reg_addr_in(h_addr), .reg_wdata_in(h_wd), .reg_wr_in(h_wr), .reg_rd_in(h_rd),
        .reg_rdata_out(h_rdata), .play_l_in(play_l), .play_r_in(play_r),
        .play_take_out(h_take),
        .rec_l_out(rec_l), .rec_r_out(rec_r), .rec_valid_out(rec_v));
    asp_link_checker asp_link_checker_i (.clk_in(clk_in), .srst_in(srst_in),
        .bclk_dev_o(asp_if_i.bclk_dev_o), .bclk_dev_oe_n(asp_if_i.bclk_dev_oe_n),
        .bclk_host_o(asp_if_i.bclk_host_o), .bclk_host_oe_n(asp_if_i.bclk_host_oe_n),
        .fclk_dev_o(asp_if_i.fclk_dev_o), .fclk_dev_oe_n(asp_if_i.fclk_dev_oe_n),
        .fclk_host_o(asp_if_i.fclk_host_o), .fclk_host_oe_n(asp_if_i.fclk_host_oe_n));
    ////////////////////////////////////////////////////////////////////////////////
    always #50 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == LIMIT) begin
            err_count++;
            conclude();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    function automatic int flen(input logic [2:0] c);
        return (c == 3'h1) ? 32 : (c == 3'h2) ? 48 : (c == 3'h3) ? 128 : (c == 3'h4) ? 256 : 64;
    endfunction : flen
    function automatic int fdly(input logic [1:0] c);
        return (c == 2'h0) ? 1 : (c == 2'h1) ? 0 : (c == 2'h2) ? 8 : 16;
    endfunction : fdly
    function automatic int fslots(input logic [1:0] c);
        return (c == 2'h1) ? 4 : (c == 2'h2) ? 8 : 2;
    endfunction : fslots
    task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
        n_tests++;
        if (g !== e) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic conclude();
        if (err_count == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : conclude
    task automatic wr(input logic h, input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_in);
        if (h) begin
            h_wr <= 1'b1;
            h_addr <= a[1:0];
            h_wd <= d;
        end else begin
            c_wr <= 1'b1;
            c_addr <= a;
            c_wd <= d;
        end
        @(posedge clk_in);
        h_wr <= 1'b0;
        c_wr <= 1'b0;
    endtask : wr
    task automatic rdc(input logic h, input logic [15:0] a, input logic [7:0] e);
        @(posedge clk_in);
        if (h) begin
            h_rd <= 1'b1;
            h_addr <= a[1:0];
        end else begin
            c_rd <= 1'b1;
            c_addr <= a;
        end
        @(posedge clk_in);
        h_rd <= 1'b0;
        c_rd <= 1'b0;
        @(negedge clk_in);
        chk("reg_read", {16'h0, e}, {16'h0, h ? h_rdata : c_rdata});
    endtask : rdc
    // Counts sampling edges from the left frame start edge, then shifts in one word
    task automatic grab(input logic line, input int idx, input logic lsbf, output logic [23:0] w);
        int n;
        logic bp;
        logic fp;
        n = -1;
        w = 24'h0;
        bp = asp_if_i.bclk;
        fp = asp_if_i.fclk;
        while (n < idx + 24) begin
            @(negedge clk_in);
            if (n < 0 && asp_if_i.fclk !== fp && asp_if_i.fclk === fpol) n = 0;
            else if (n >= 0 && asp_if_i.bclk !== bp && asp_if_i.bclk === !bpol) begin
                if (n >= idx) w[lsbf ? n - idx : 23 - (n - idx)] = line ? asp_if_i.dac_data
                                                                       : asp_if_i.adc_data;
                n++;
            end
            bp = asp_if_i.bclk;
            fp = asp_if_i.fclk;
        end
    endtask : grab
    // Also counts sample-take pulses of both ends within the one frame
    task automatic period(output int c, output int t);
        int k;
        logic fp;
        c = 0;
        t = 0;
        k = 0;
        fp = asp_if_i.fclk;
        while (k < 2) begin
            @(negedge clk_in);
            if (k == 1) c++;
            if (k == 1 && c_take === 1'b1) t++;
            if (k == 1 && h_take === 1'b1) t++;
            if (asp_if_i.fclk !== fp && asp_if_i.fclk === fpol) k++;
            fp = asp_if_i.fclk;
        end
    endtask : period
    task automatic waitv(input logic h);
        int k;
        k = 0;
        do begin
            @(negedge clk_in);
            k++;
        end while (!(h ? rec_v === 1'b1 : dac_v === 1'b1) && k < 5000);
    endtask : waitv
    ////////////////////////////////////////////////////////////////////////////////
    task automatic run(input logic [7:0] a, input logic [7:0] b, input logic [1:0] pr,
                       input logic cm);
        int len;
        int d;
        int sw;
        int per;
        int tk;
        logic [23:0] w;
        len = flen(b[7:5]);
        d = fdly(b[1:0]);
        sw = len / fslots(a[2:1]);
        bpol = a[4];
        fpol = a[3];
        @(posedge clk_in);
        srst_in <= 1'b1;
        adc_l <= 24'(rnd());
        adc_r <= 24'(rnd());
        play_l <= 24'(rnd());
        play_r <= 24'(rnd());
        @(posedge clk_in);
        srst_in <= 1'b0;
        wr(1'b1, 16'h0001, b);
        wr(1'b1, 16'h0002, {6'h0, pr});
        wr(1'b1, 16'h0000, a | {7'h0, !cm});
        wr(1'b0, ASP_PAIR_DAC_OFS, {1'b0, pr, 5'h0});
        wr(1'b0, ASP_PAIR_ADC_OFS, {6'h0, pr});
        rdc(1'b0, ASP_PAIR_DAC_OFS, {1'b0, pr, 5'h0});
        wr(1'b0, ASP_CTRL_B_OFS, b);
        wr(1'b0, ASP_CTRL_A_OFS, a | {7'h0, cm});
        rdc(1'b0, ASP_CTRL_A_OFS, a | {7'h0, cm});
        repeat (len * 8) @(posedge clk_in);
        period(per, tk);
        chk("frame_len", 24'(len * 8), 24'(per));
        chk("take_count", 24'h000002, 24'(tk));
        // Words that overrun their slot are not checked
        if (sw >= d + 24) begin
            if (!a[5]) begin
                grab(1'b0, (2 * pr + b[4]) * sw + d, b[2], w);
                chk("adc_left_wire", adc_l, w);
                grab(1'b1, (2 * pr + !b[3]) * sw + d, b[2], w);
                chk("dac_right_wire", play_r, w);
            end
            waitv(1'b1);
            chk("rec_left", adc_l, rec_l);
            chk("rec_right", adc_r, rec_r);
            waitv(1'b0);
            chk("dac_left", play_l, dac_l);
            chk("dac_right", play_r, dac_r);
        end
    endtask : run
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge clk_in);
        srst_in <= 1'b0;
        rdc(1'b0, ASP_CTRL_A_OFS, ASP_CTRL_RST);
        rdc(1'b0, ASP_CTRL_B_OFS, ASP_CTRL_RST);
        rdc(1'b1, 16'h0000, 8'h00);
        rdc(1'b1, 16'h0001, 8'h00);
        wr(1'b0, 16'h4019, 8'hff);
        rdc(1'b0, 16'h4019, 8'h00);
        wr(1'b1, 16'h0003, 8'hff);
        rdc(1'b1, 16'h0003, 8'h00);
        run(8'h00, 8'h00, 2'h0, 1'b1);
        run(8'h18, 8'h05, 2'h0, 1'b0);
        run(8'h00, 8'h02, 2'h0, 1'b1);
        run(8'h00, 8'h63, 2'h0, 1'b0);
        run(8'h02, 8'h79, 2'h1, 1'b1);
        run(8'h04, 8'h98, 2'h3, 1'b0);
        run(8'h14, 8'h84, 2'h2, 1'b1);
        run(8'h20, 8'h01, 2'h0, 1'b1);
        run(8'h22, 8'h61, 2'h0, 1'b0);
        run(8'h00, 8'h21, 2'h0, 1'b1);
        run(8'h00, 8'h41, 2'h0, 1'b0);
        conclude();
    end
endmodule : audio_serial_port_formatter_tb
